// File: design/sarseq_pkg.sv
// shared constants, types and helpers of the sar converter sequencer
package sarseq_pkg;
  localparam logic [15:0] ADDR_MODE = 16'hff80;
  localparam logic [15:0] ADDR_CHAN = 16'hff81;
  localparam logic [15:0] ADDR_RESULT = 16'hff18;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_TRG_BIT = 6;
  localparam int MODE_TIME_HI = 5;
  localparam int MODE_TIME_LO = 3;
  localparam int MODE_EDGE_HI = 2;
  localparam int MODE_EDGE_LO = 1;
  localparam int CHAN_W = 3;
  localparam int SAR_W = 10;
  localparam int RES_PAD = 6;
  localparam logic [3:0] SAR_MSB = 4'h9;
  localparam logic [3:0] SAR_LSB = 4'h0;
  localparam logic [SAR_W-1:0] SAR_ONE = 10'h001;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] TIME_144 = 3'h0;
  localparam logic [2:0] TIME_120 = 3'h1;
  localparam logic [2:0] TIME_96 = 3'h2;
  localparam logic [2:0] TIME_72 = 3'h4;
  localparam logic [2:0] TIME_60 = 3'h5;
  localparam logic [2:0] TIME_48 = 3'h6;
  localparam logic [7:0] CYC_144 = 8'h90;
  localparam logic [7:0] CYC_120 = 8'h78;
  localparam logic [7:0] CYC_96 = 8'h60;
  localparam logic [7:0] CYC_72 = 8'h48;
  localparam logic [7:0] CYC_60 = 8'h3c;
  localparam logic [7:0] CYC_48 = 8'h30;
  // ten bit slots plus two slots of sampling, a sixth of the total
  localparam logic [7:0] PHASE_SLOTS = 8'h0c;
  localparam logic [7:0] BIT_PHASES = 8'h0a;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11,
    ST_WAIT = 2'b10
  } sarseq_state_e;

  // prohibited codes fall back to the slowest, safest setting
  function automatic logic [7:0] conv_cycles(input logic [2:0] code);
    case (code)
      TIME_120: conv_cycles = CYC_120;
      TIME_96: conv_cycles = CYC_96;
      TIME_72: conv_cycles = CYC_72;
      TIME_60: conv_cycles = CYC_60;
      TIME_48: conv_cycles = CYC_48;
      default: conv_cycles = CYC_144;
    endcase
  endfunction

  function automatic logic [7:0] bit_cycles(input logic [2:0] code);
    bit_cycles = conv_cycles(code) / PHASE_SLOTS;
  endfunction

  function automatic logic [7:0] sample_cycles(input logic [2:0] code);
    sample_cycles = 8'(conv_cycles(code) - BIT_PHASES * bit_cycles(code));
  endfunction
endpackage

// File: design/sarseq_trig_edge.sv
// external trigger synchroniser and valid edge detector
`timescale 1ns/1ps
`default_nettype none
module sarseq_trig_edge
  import sarseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic trig_pin_i,
  input wire logic [1:0] edge_sel_i,
  output logic edge_o
);
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic change;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= trig_pin_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a level only counts once two stages agree, which filters one-cycle glitches
  assign change = (sync2_ff == sync3_ff) && (sync2_ff != level_ff);

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      level_ff <= 1'b0;
    else if (change)
      level_ff <= sync2_ff;
  end

  always_comb
  begin
    case (edge_sel_i)
      EDGE_FALL: edge_o = change && !sync2_ff;
      EDGE_RISE: edge_o = change && sync2_ff;
      EDGE_BOTH: edge_o = change;
      default: edge_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: design/sarseq_phase_timer.sv
// down counter that times the sampling and bit decision phases
`timescale 1ns/1ps
`default_nettype none
module sarseq_phase_timer
  import sarseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [7:0] len_i,
  input wire logic stop_i,
  output logic expired_o
);
  logic [7:0] cnt_ff;
  logic run_ff;

  // expired stands in the last cycle of a phase of len_i cycles
  assign expired_o = run_ff && (cnt_ff == 8'h00);

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_ff <= 8'h00;
      run_ff <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_ff <= 8'(len_i - 8'h01);
      run_ff <= 1'b1;
    end
    else if (stop_i || expired_o)
      run_ff <= 1'b0;
    else if (run_ff)
      cnt_ff <= 8'(cnt_ff - 8'h01);
  end
endmodule
`default_nettype wire

// File: design/sarseq_top.sv
// sar converter sequencer: registers, start control and bit decisions
`timescale 1ns/1ps
`default_nettype none
module sarseq_top
  import sarseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  output logic [15:0] cpu_rdata_o,
  input wire logic external_conv_trigger_i,
  input wire logic comp_ge_i,
  output logic [SAR_W-1:0] tap_code_o,
  output logic [CHAN_W-1:0] analog_sel_o,
  output logic sample_hold_o,
  output logic busy_o,
  output logic conversion_end_irq_o
);
  logic [7:0] converter_mode_ff;
  logic [7:0] channel_select_ff;
  logic [15:0] conversion_result_ff;
  logic [15:0] rdata_ff;
  logic [SAR_W-1:0] approximation_register_ff;
  logic [3:0] bit_idx_ff;
  logic irq_ff;
  sarseq_state_e state_ff;
  sarseq_state_e nxt_state;

  logic mode_wr;
  logic chan_wr;
  logic reg_wr;
  logic [7:0] mode_now;
  logic en_now;
  logic trg_now;
  logic [2:0] time_now;
  logic trig_edge;
  logic expired;
  logic bit_done;
  logic last_bit;
  logic [SAR_W-1:0] cur_bit;
  logic [SAR_W-1:0] decided;
  logic load_timer;
  logic stop_timer;
  logic [7:0] load_len;

  assign mode_wr = cpu_wr_i && (cpu_addr_i == ADDR_MODE);
  assign chan_wr = cpu_wr_i && (cpu_addr_i == ADDR_CHAN);
  assign reg_wr = mode_wr || chan_wr;

  // the value the mode register holds after this cycle's write, if any
  always_comb
  begin
    mode_now = converter_mode_ff;
    if (mode_wr)
      mode_now = {cpu_wdata_i[7:1], 1'b0};
  end

  assign en_now = mode_now[MODE_EN_BIT];
  assign trg_now = mode_now[MODE_TRG_BIT];
  assign time_now = mode_now[MODE_TIME_HI:MODE_TIME_LO];

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      converter_mode_ff <= MODE_RESET;
    else
      converter_mode_ff <= mode_now;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      channel_select_ff <= CHAN_RESET;
    else if (chan_wr)
      channel_select_ff <= {5'h00, cpu_wdata_i[CHAN_W-1:0]};
  end

  // waiting keeps no channel copy, so a write while waiting is used next time
  assign analog_sel_o = channel_select_ff[CHAN_W-1:0];

  // edges only count while waiting, so a running conversion ignores them
  sarseq_trig_edge u_trig_edge (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .trig_pin_i(external_conv_trigger_i),
    .edge_sel_i(converter_mode_ff[MODE_EDGE_HI:MODE_EDGE_LO]),
    .edge_o(trig_edge)
  );

  sarseq_phase_timer u_phase_timer (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .load_i(load_timer),
    .len_i(load_len),
    .stop_i(stop_timer),
    .expired_o(expired)
  );

  assign bit_done = (state_ff == ST_CONVERT) && expired;
  assign last_bit = bit_done && (bit_idx_ff == SAR_LSB);
  assign cur_bit = SAR_ONE << bit_idx_ff;
  // keep the trial bit only when the input is at or above the tap
  assign decided = comp_ge_i ? approximation_register_ff
                             : (approximation_register_ff & ~cur_bit);

  always_comb
  begin
    nxt_state = state_ff;
    if (reg_wr)
    begin
      if (!en_now)
        nxt_state = ST_IDLE;
      else if (trg_now)
        nxt_state = ST_WAIT;
      else
        nxt_state = ST_SAMPLE;
    end
    else
    begin
      case (state_ff)
        ST_WAIT:
          if (trig_edge)
            nxt_state = ST_SAMPLE;
        ST_SAMPLE:
          if (expired)
            nxt_state = ST_CONVERT;
        ST_CONVERT:
          if (last_bit)
            nxt_state = trg_now ? ST_WAIT : ST_SAMPLE;
        default:
          nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // phase lengths follow the time code; software keeps it still while running
  always_comb
  begin
    load_timer = 1'b0;
    load_len = bit_cycles(time_now);
    if (nxt_state == ST_SAMPLE && (state_ff != ST_SAMPLE || reg_wr))
    begin
      load_timer = 1'b1;
      load_len = sample_cycles(time_now);
    end
    else if (nxt_state == ST_CONVERT && (state_ff == ST_SAMPLE || bit_done))
      load_timer = 1'b1;
  end

  assign stop_timer = (nxt_state == ST_IDLE) || (nxt_state == ST_WAIT);

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      approximation_register_ff <= '0;
      bit_idx_ff <= SAR_MSB;
    end
    else if (state_ff == ST_SAMPLE && nxt_state == ST_CONVERT)
    begin
      approximation_register_ff <= SAR_ONE << SAR_MSB;
      bit_idx_ff <= SAR_MSB;
    end
    else if (bit_done && !last_bit && !reg_wr)
    begin
      approximation_register_ff <= decided | (cur_bit >> 1);
      bit_idx_ff <= 4'(bit_idx_ff - 4'h1);
    end
  end

  // the trial value is the tap code; each step halves the remaining range
  assign tap_code_o = approximation_register_ff;

  // a register write in the same cycle wins and the result is dropped
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      conversion_result_ff <= RESULT_RESET;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= last_bit && !reg_wr;
      if (last_bit && !reg_wr)
        conversion_result_ff <= {decided, {RES_PAD{1'b0}}};
    end
  end

  assign conversion_end_irq_o = irq_ff;
  assign sample_hold_o = (state_ff == ST_SAMPLE);
  assign busy_o = (state_ff == ST_SAMPLE) || (state_ff == ST_CONVERT);

  // read data is registered; a read beside a result write returns the old one
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_ff <= 16'h0000;
    else if (cpu_rd_i)
    begin
      case (cpu_addr_i)
        ADDR_MODE: rdata_ff <= {8'h00, converter_mode_ff};
        ADDR_CHAN: rdata_ff <= {8'h00, channel_select_ff};
        ADDR_RESULT: rdata_ff <= conversion_result_ff;
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  assign cpu_rdata_o = rdata_ff;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence seq_bit_end;
    state_ff == ST_CONVERT && expired;
  endsequence

  sequence seq_conv_done;
    seq_bit_end ##0 bit_idx_ff == SAR_LSB;
  endsequence

  chk_chan_read_pad: assert property (
    cpu_rd_i && cpu_addr_i == ADDR_CHAN |=> cpu_rdata_o[15:CHAN_W] == '0)
    else $error("channel read shows nonzero upper bits");

  chk_result_low_zero: assert property (
    conversion_result_ff[RES_PAD-1:0] == '0)
    else $error("result low bits not zero");

  chk_mode_bit_zero: assert property (
    mode_wr |=> converter_mode_ff[0] == 1'b0)
    else $error("mode bit 0 stored as one");

  chk_done_result_irq: assert property (
    seq_conv_done ##0 !reg_wr |=> conversion_end_irq_o
      && conversion_result_ff[15:RES_PAD] == $past(decided))
    else $error("conversion end without result or interrupt");

  chk_write_wins_end: assert property (
    seq_conv_done ##0 reg_wr |=> !conversion_end_irq_o
      && $stable(conversion_result_ff))
    else $error("result written despite register write");

  chk_disable_halts: assert property (
    mode_wr && !cpu_wdata_i[MODE_EN_BIT] |=> state_ff == ST_IDLE && !busy_o)
    else $error("conversion not halted on disable");

  chk_hw_waits_after: assert property (
    conversion_end_irq_o && converter_mode_ff[MODE_TRG_BIT]
      |-> state_ff == ST_WAIT)
    else $error("hardware mode did not return to waiting");

  chk_sw_repeats: assert property (
    conversion_end_irq_o && !converter_mode_ff[MODE_TRG_BIT]
      |-> state_ff == ST_SAMPLE)
    else $error("software mode did not restart");

  chk_first_tap_half: assert property (
    state_ff == ST_SAMPLE && expired && !reg_wr
      |=> tap_code_o == (SAR_ONE << SAR_MSB) && bit_idx_ff == SAR_MSB)
    else $error("first comparison not at half reference");

  chk_trig_ignored: assert property (
    state_ff == ST_CONVERT && !reg_wr && !last_bit |=> state_ff == ST_CONVERT)
    else $error("conversion left early");
endmodule
`default_nettype wire

// File: verif/sarseq_comp_model.sv
// behavioural sample-and-hold and comparator facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sarseq_comp_model
  import sarseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sample_hold_i,
  input wire logic [CHAN_W-1:0] analog_sel_i,
  input wire logic [SAR_W-1:0] tap_code_i,
  input wire logic [87:0] levels_i,
  output logic comp_ge_o
);
  // levels are in half steps, taps sit half a step low so codes round
  logic [10:0] held;
  always_ff @(posedge mclk_i)
  begin
    if (sample_hold_i)
    begin
      held <= levels_i[analog_sel_i*11 +: 11];
    end
  end
  assign comp_ge_o = ({1'b0, held} + 12'h001) >= {1'b0, tap_code_i, 1'b0};
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the sar converter sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sarseq_pkg::*;
;
  logic mclk_i;
  logic reset_n_i;
  logic [15:0] cpu_addr_i;
  logic [15:0] cpu_wdata_i;
  logic cpu_wr_i;
  logic cpu_rd_i;
  logic [15:0] cpu_rdata_o;
  logic external_conv_trigger_i;
  logic comp_ge_i;
  logic [SAR_W-1:0] tap_code_o;
  logic [CHAN_W-1:0] analog_sel_o;
  logic sample_hold_o;
  logic busy_o;
  logic conversion_end_irq_o;
  logic [87:0] levels;
  logic [15:0] rd_val;
  logic [15:0] old;
  logic [2:0] ch;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [15:0] regs [4] = '{ADDR_MODE, ADDR_CHAN, ADDR_RESULT, 16'hff82};
  int n_errors;
  int checks_done;
  int irq_cnt;
  int seed;
  int n;
  int k;
  int cyc;

  sarseq_top dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
    .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o),
    .external_conv_trigger_i(external_conv_trigger_i),
    .comp_ge_i(comp_ge_i), .tap_code_o(tap_code_o),
    .analog_sel_o(analog_sel_o), .sample_hold_o(sample_hold_o),
    .busy_o(busy_o), .conversion_end_irq_o(conversion_end_irq_o));
  sarseq_comp_model comp_u (.mclk_i(mclk_i), .sample_hold_i(sample_hold_o),
    .analog_sel_i(analog_sel_o), .tap_code_i(tap_code_o),
    .levels_i(levels), .comp_ge_o(comp_ge_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // counted in the time step of the pulse, so a snapshot just after it agrees
  always @(posedge conversion_end_irq_o) irq_cnt++;

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge mclk_i);
    cpu_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge mclk_i);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge mclk_i);
    cpu_rd_i <= 1'b0;
    #1 rd_val = cpu_rdata_o;
  endtask

  task automatic cycles(input int c);
    repeat (c) @(posedge mclk_i);
  endtask

  // counts edges up to the completion pulse; samp > 0 also checks phases
  task automatic wait_irq(input int samp);
    n = 0;
    do
    begin
      @(posedge mclk_i);
      #1 n++;
      if (samp > 0 && n == 1)
        chk("sampling", 16'(sample_hold_o), 16'h0001);
      if (samp > 0 && n == samp + 1)
      begin
        chk("first tap", 16'(tap_code_o), 16'h0200);
        chk("hold end", 16'(sample_hold_o), 16'h0000);
      end
    end
    while (conversion_end_irq_o !== 1'b1 && n < 400);
  endtask

  task automatic new_levels();
    @(posedge mclk_i);
    for (int i = 1; i < 7; i++)
    begin
      levels[i*11 +: 11] <= 11'($random(seed));
    end
    // range ends on channels 0 and 7
    levels[10:0] <= 11'h000;
    levels[87:77] <= 11'h7ff;
  endtask

  function automatic int exp_cyc(input logic [2:0] c);
    case (c)
      3'h1: return 120;
      3'h2: return 96;
      3'h4: return 72;
      3'h5: return 60;
      3'h6: return 48;
      default: return 144;
    endcase
  endfunction

  function automatic logic [15:0] exp_res(input logic [2:0] c);
    logic [11:0] r;
    r = ({1'b0, levels[c*11 +: 11]} + 12'h001) >> 1;
    if (r > 12'h03ff)
      r = 12'h03ff;
    return {r[9:0], 6'h00};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial
  begin
    seed = 32'h9a80_1a35;
    n_errors = 0;
    checks_done = 0;
    irq_cnt = 0;
    reset_n_i = 1'b0;
    cpu_addr_i = 16'h0000;
    cpu_wdata_i = 16'h0000;
    cpu_wr_i = 1'b0;
    cpu_rd_i = 1'b0;
    external_conv_trigger_i = 1'b0;
    levels = '0;
    cycles(8);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd(regs[i]);
      chk("reset value", rd_val, 16'h0000);
    end
    wr(ADDR_CHAN, 16'h00ff);
    rd(ADDR_CHAN);
    chk("channel mask", rd_val, 16'h0007);
    wr(ADDR_MODE, 16'h003f);
    rd(ADDR_MODE);
    chk("mode mask", rd_val, 16'h003e);
    wr(ADDR_RESULT, 16'hffff);
    rd(ADDR_RESULT);
    chk("result read only", rd_val, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_MODE, 16'h0000);
      new_levels();
      ch = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($random(seed));
      wr(ADDR_CHAN, {13'h0000, ch});
      wr(ADDR_MODE, {8'h00, 2'b10, codes[i], 3'b000});
      cyc = exp_cyc(codes[i]);
      wait_irq(cyc - 10 * (cyc / 12));
      chk("conv cycles", 16'(n), 16'(cyc));
      chk("analog sel", 16'(analog_sel_o), 16'(ch));
      rd(ADDR_RESULT);
      chk("result", rd_val, exp_res(ch));
      wait_irq(0);
      // the result read took two of the cycles before the count started
      chk("repeat cycles", 16'(n), 16'(cyc - 2));
    end
    $display("test software timing done");
    wr(ADDR_MODE, 16'h0000);
    new_levels();
    wr(ADDR_MODE, 16'h00b0);
    cycles(20);
    wr(ADDR_CHAN, 16'h0005);
    wait_irq(0);
    chk("abort restart", 16'(n), 16'h0030);
    rd(ADDR_RESULT);
    chk("new channel", rd_val, exp_res(3'h5));
    wait_irq(0);
    old = exp_res(3'h5);
    cycles(20);
    levels[55 +: 11] <= ~levels[55 +: 11];
    wait_irq(0);
    k = irq_cnt;
    cycles(46);
    wr(ADDR_CHAN, 16'h0002);
    rd(ADDR_RESULT);
    chk("collided result", rd_val, old);
    chk("collision irq", 16'(irq_cnt - k), 16'h0000);
    wait_irq(0);
    chk("collision restart", 16'(n), 16'h002e);
    $display("test abort and collision done");
    cycles(10);
    k = irq_cnt;
    wr(ADDR_MODE, 16'h0000);
    #1 chk("halt", 16'(busy_o), 16'h0000);
    cycles(200);
    chk("stopped", 16'(irq_cnt - k), 16'h0000);
    $display("test stop done");
    for (int e = 0; e < 4; e++)
    begin
      new_levels();
      k = irq_cnt;
      // edge field set with enable and hardware trigger on, bit 0 left zero
      wr(ADDR_MODE, {8'h00, 2'b11, 3'h6, 2'(e), 1'b0});
      cycles(10);
      #1 chk("waiting", 16'(busy_o), 16'h0000);
      cycles(1);
      external_conv_trigger_i <= 1'b1;
      cycles(20);
      external_conv_trigger_i <= 1'b0;
      cycles(80);
      chk("trig convs", 16'(irq_cnt - k), 16'(e != 0));
      #1 chk("back waiting", 16'(busy_o), 16'h0000);
    end
    $display("test trigger edges done");
    k = irq_cnt;
    wr(ADDR_MODE, 16'h00f4);
    wr(ADDR_CHAN, 16'h0001);
    external_conv_trigger_i <= 1'b1;
    cycles(20);
    wr(ADDR_CHAN, 16'h0003);
    cycles(80);
    chk("hw abort", 16'(irq_cnt - k), 16'h0000);
    external_conv_trigger_i <= 1'b0;
    wr(ADDR_CHAN, 16'h0006);
    external_conv_trigger_i <= 1'b1;
    wait_irq(0);
    chk("hw channel", 16'(analog_sel_o), 16'h0006);
    rd(ADDR_RESULT);
    chk("hw result", rd_val, exp_res(3'h6));
    cycles(100);
    chk("single conv", 16'(irq_cnt - k), 16'h0001);
    $display("test hardware channel done");
    wrap_up();
  end
endmodule
`default_nettype wire
